/* design/pzf_pkg.sv */
/*
 * pzf_pkg: register offsets, field positions, reset values and encodings
 * for the phase, zone and frequency register group.
 * Assumes an 8-bit register port driven by the serial management engine.
 */
package pzf_pkg;

    // =====================================================================
    // register offsets
    // =====================================================================
    localparam logic [7:0] OFS_FREQ_STRAP_STATUS = 8'h2f;
    localparam logic [7:0] OFS_FREQ_CONFIG = 8'h30;
    localparam logic [7:0] OFS_DOWNSTEP_PHASE_ENABLE = 8'h31;
    localparam logic [7:0] OFS_SAVING_PIN_LEVEL = 8'h32;
    localparam logic [7:0] OFS_PHASE_ENABLED_STATUS = 8'h33;
    localparam logic [7:0] OFS_ZONE_ENABLE_MASK = 8'h34;
    localparam logic [7:0] OFS_ZONE_STRAP_STATUS = 8'h35;
    localparam logic [7:0] OFS_ZONE_CONFIG = 8'h36;

    // =====================================================================
    // field widths and positions
    // =====================================================================
    localparam int FREQ_W = 5;
    localparam int ZONE_FIELD_W = 3;
    localparam int ZONE_COUNT = 5;
    localparam int PHASE_COUNT = 4;
    localparam int ZONE_FIRST_LSB = 3;
    localparam int ZONE_SECOND_LSB = 0;
    localparam int DOWNSTEP_BIT = 0;

    // second-function latch select bits
    localparam int SECFN_FREQ_BIT = 5;
    localparam int SECFN_ZONE_BIT = 1;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic [4:0] FREQ_RESET = 5'h00;
    localparam logic [2:0] ZONE_FIELD_RESET = 3'h0;
    localparam logic DOWNSTEP_RESET = 1'b1;
    localparam logic [4:0] ZONE_MASK_RESET = 5'h1f;
    localparam logic [7:0] SECFN_RESET = 8'h00;

    // =====================================================================
    // encodings
    // =====================================================================
    localparam logic [1:0] SAVE_LVL_MID = 2'h0;
    localparam logic [1:0] SAVE_LVL_LOW = 2'h1;
    localparam logic [1:0] SAVE_LVL_HIGH = 2'h2;
    localparam logic [2:0] ZONE_CODE_MAX_FIRST = 3'h4;
    localparam logic [2:0] ZONE_CODE_ALIAS = 3'h4;
    localparam logic [2:0] ZONE_LEVEL_TOP_SECOND = 3'h3;

    // =====================================================================
    // timing: cycles from reset release until the synchronised straps are valid
    // =====================================================================
    localparam int SYNC_DEPTH = 2;
    localparam logic [1:0] PU_LOAD_CYC = 2'h2;

endpackage : pzf_pkg

/* design/pzf_sync.sv */
/*
 * pzf_sync: two-flip-flop synchroniser for a bundle of level inputs.
 * Assumes each bit is a slow level; no multi-bit coherency is promised.
 */
`timescale 1ns/1ns
module pzf_sync #(
    parameter int W = 1
) (
    input wire logic clk,         // system clock
    input wire logic rstn,        // async reset, active low
    input wire logic [W-1:0] d,   // asynchronous levels
    output logic [W-1:0] q        // synchronised levels
);

    // =====================================================================
    // two-stage chain
    // =====================================================================
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule : pzf_sync

/* design/pzf_regs.sv */
/*
 * pzf_regs: frequency, downstep, power-saving level, phase status and
 * low-power-zone registers of a multiphase buck controller.
 * Assumes a register port from the serial management engine on CLK_SYS,
 * strap codes from the strap measurement front end, and the two
 * second-function latch bytes from their own register logic.
 */
// Overview of operation
// R1 - Freq status and config use bits 4:0; status holds an even strap code, config any code.
// R2 - One downstep gating bit at bit 0 of its register, bits 7:1 reserved.
// R3 - The downstep gating bit resets to 1 and writing 0 disables the downstep change.
// R4 - The power-saving pin level is read-only at bits 1:0, bits 7:2 reserved.
// R5 - The pin level reads 00 for mid, 01 for low and 10 for high.
// R6 - Phase status reads one enabled bit per phase in bits 3:0, phase 1 at bit 0.
// R7 - A 5-bit zone enable mask, zone 1 at bit 0, applies while the saving input is low.
// R8 - All mask bits reset to 1 and bits 7:5 are reserved.
// R9 - Zone status and config registers are loaded from the two zone straps at power-on.
// R10 - Zone status reloads from the straps on every rising edge of the enable input.
// R11 - The zone config value is used only while the zone select of the latch bytes is set.
// R12 - Zone fields sit at 5:3 and 2:0, reset 000; first-field codes 0..4 give levels 0..4.
// R13 - Second-field codes 0..3 give levels 0..3, 100 gives level 3, 101..111 are reserved.
// R14 - Freq config replaces the strap value only when both latch bytes set the freq select.
// R15 - Host writes the same byte to both latches; source switches only when they agree.
// R16 - Reserved bits read zero; writes to reserved bits or read-only registers are ignored.
`timescale 1ns/1ns
module pzf_regs (
    input wire logic CLK_SYS,              // 125 MHz system clock
    input wire logic RSTN,                 // power-on reset, async, active low
    input wire logic [7:0] REG_ADDR,       // register offset
    input wire logic REG_WR,               // write strobe, one cycle
    input wire logic [7:0] REG_WDATA,      // write data
    input wire logic REG_RD,               // read strobe, one cycle
    output logic [7:0] REG_RDATA,          // read data, registered
    input wire logic [7:0] SECFN_LATCH_A,  // second-function latch byte A
    input wire logic [7:0] SECFN_LATCH_B,  // second-function latch byte B
    input wire logic POWER_SAVING_INPUT_LOW,   // saving pin below mid band
    input wire logic POWER_SAVING_INPUT_HIGH,  // saving pin above mid band
    input wire logic ENABLE_PIN,           // controller enable pin
    input wire logic [4:0] FREQ_STRAP_SELECT,  // measured frequency strap code
    input wire logic [2:0] ZONE_STRAP_FIRST,   // measured first zone strap code
    input wire logic [2:0] ZONE_STRAP_SECOND,  // measured second zone strap code
    input wire logic [3:0] PHASE_ACTIVE,   // per-phase enable from the modulator
    output logic [4:0] FREQ_CODE,          // frequency code in use
    output logic VOLTAGE_CODE_DOWNSTEP_EN, // downstep may change phases in light load
    output logic [4:0] ZONE_ENABLE_MASK,   // zone enables, valid while saving input low
    output logic ZONE_MODE_ACTIVE,         // saving input low, zone settings apply
    output logic [2:0] ZONE_FIRST_LEVEL,   // first zone level in use
    output logic [2:0] ZONE_SECOND_LEVEL   // second zone level in use
);

    // =====================================================================
    // input synchronisation
    // =====================================================================
    localparam int SYNC_W = 2 + 1 + pzf_pkg::FREQ_W + 2 * pzf_pkg::ZONE_FIELD_W;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic save_low_s;
    logic save_high_s;
    logic en_s;
    logic [4:0] freq_strap_s;
    logic [2:0] zone_first_s;
    logic [2:0] zone_second_s;

    assign sync_in = {POWER_SAVING_INPUT_LOW, POWER_SAVING_INPUT_HIGH, ENABLE_PIN,
                      FREQ_STRAP_SELECT, ZONE_STRAP_FIRST, ZONE_STRAP_SECOND};

    pzf_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .d(sync_in),
        .q(sync_out)
    );

    assign {save_low_s, save_high_s, en_s, freq_strap_s, zone_first_s, zone_second_s} = sync_out;

    // =====================================================================
    // register state
    // =====================================================================
    logic [1:0] pu_cnt_r;
    logic [1:0] pu_cnt_nxt;
    logic pu_done_r;
    logic pu_done_nxt;
    logic en_prev_r;
    logic en_prev_nxt;
    logic [4:0] freq_status_r;
    logic [4:0] freq_status_nxt;
    logic [4:0] freq_cfg_r;
    logic [4:0] freq_cfg_nxt;
    logic downstep_r;
    logic downstep_nxt;
    logic [4:0] zone_mask_r;
    logic [4:0] zone_mask_nxt;
    logic [5:0] zone_status_r;
    logic [5:0] zone_status_nxt;
    logic [5:0] zone_cfg_r;
    logic [5:0] zone_cfg_nxt;
    logic sel_freq_r;
    logic sel_freq_nxt;
    logic sel_zone_r;
    logic sel_zone_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic strap_load;
    logic en_rise;
    logic [5:0] zone_strap_word;
    logic [1:0] save_level;
    logic [7:0] rd_mux;

    assign zone_strap_word = {zone_first_s, zone_second_s};
    assign en_rise = en_s && !en_prev_r;
    assign strap_load = !pu_done_r && (pu_cnt_r == pzf_pkg::PU_LOAD_CYC);

    // =====================================================================
    // power-saving pin level encoding
    // =====================================================================
    always_comb
    begin
        if (save_high_s)
            save_level = pzf_pkg::SAVE_LVL_HIGH;  // [R5]
        else if (save_low_s)
            save_level = pzf_pkg::SAVE_LVL_LOW;   // [R5]
        else
            save_level = pzf_pkg::SAVE_LVL_MID;   // [R5]
    end

    // =====================================================================
    // read multiplexer
    // =====================================================================
    always_comb
    begin
        rd_mux = 8'h00;  // [R16]
        case (REG_ADDR)
            pzf_pkg::OFS_FREQ_STRAP_STATUS: rd_mux = {3'h0, freq_status_r};  // [R1]
            pzf_pkg::OFS_FREQ_CONFIG: rd_mux = {3'h0, freq_cfg_r};  // [R1]
            pzf_pkg::OFS_DOWNSTEP_PHASE_ENABLE: rd_mux = {7'h00, downstep_r};  // [R2]
            pzf_pkg::OFS_SAVING_PIN_LEVEL: rd_mux = {6'h00, save_level};  // [R4]
            pzf_pkg::OFS_PHASE_ENABLED_STATUS: rd_mux = {4'h0, PHASE_ACTIVE};  // [R6]
            pzf_pkg::OFS_ZONE_ENABLE_MASK: rd_mux = {3'h0, zone_mask_r};  // [R8]
            pzf_pkg::OFS_ZONE_STRAP_STATUS: rd_mux = {2'h0, zone_status_r};  // [R12]
            pzf_pkg::OFS_ZONE_CONFIG: rd_mux = {2'h0, zone_cfg_r};  // [R12]
            default: rd_mux = 8'h00;  // [R16]
        endcase
    end

    // =====================================================================
    // next-state logic
    // =====================================================================
    always_comb
    begin
        pu_cnt_nxt = pu_cnt_r;
        pu_done_nxt = pu_done_r;
        en_prev_nxt = en_s;
        freq_status_nxt = freq_status_r;
        freq_cfg_nxt = freq_cfg_r;
        downstep_nxt = downstep_r;
        zone_mask_nxt = zone_mask_r;
        zone_status_nxt = zone_status_r;
        zone_cfg_nxt = zone_cfg_r;
        sel_freq_nxt = sel_freq_r;
        sel_zone_nxt = sel_zone_r;
        rdata_nxt = rdata_r;

        // wait for the synchroniser to fill before sampling straps
        if (!pu_done_r)
        begin
            pu_cnt_nxt = pu_cnt_r + 2'h1;
        end
        if (strap_load)
        begin
            pu_done_nxt = 1'b1;
            freq_status_nxt = {freq_strap_s[4:1], 1'b0};  // [R1]
            zone_status_nxt = zone_strap_word;  // [R9]
            zone_cfg_nxt = zone_strap_word;  // [R9]
        end
        else if (pu_done_r && en_rise)
        begin
            zone_status_nxt = zone_strap_word;  // [R10]
        end

        // source select follows the latch bytes only while they agree
        if (SECFN_LATCH_A == SECFN_LATCH_B)
        begin
            sel_freq_nxt = SECFN_LATCH_A[pzf_pkg::SECFN_FREQ_BIT];  // [R14] [R15]
            sel_zone_nxt = SECFN_LATCH_A[pzf_pkg::SECFN_ZONE_BIT];  // [R11] [R15]
        end

        // host writes: only defined bits of writable registers
        if (REG_WR)
        begin
            case (REG_ADDR)
                pzf_pkg::OFS_FREQ_CONFIG:
                begin
                    freq_cfg_nxt = REG_WDATA[4:0];  // [R1] [R16]
                end
                pzf_pkg::OFS_DOWNSTEP_PHASE_ENABLE:
                begin
                    downstep_nxt = REG_WDATA[pzf_pkg::DOWNSTEP_BIT];  // [R3]
                end
                pzf_pkg::OFS_ZONE_ENABLE_MASK:
                begin
                    zone_mask_nxt = REG_WDATA[4:0];  // [R7] [R16]
                end
                pzf_pkg::OFS_ZONE_CONFIG:
                begin
                    zone_cfg_nxt = REG_WDATA[5:0];  // [R12] [R16]
                end
                default:
                begin
                    zone_mask_nxt = zone_mask_r;  // [R16]
                end
            endcase
        end

        if (REG_RD)
        begin
            rdata_nxt = rd_mux;
        end
    end

    // =====================================================================
    // state registers
    // =====================================================================
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pu_cnt_r <= 2'h0;
            pu_done_r <= 1'b0;
            en_prev_r <= 1'b0;
            freq_status_r <= pzf_pkg::FREQ_RESET;
            freq_cfg_r <= pzf_pkg::FREQ_RESET;
            downstep_r <= pzf_pkg::DOWNSTEP_RESET;  // [R3]
            zone_mask_r <= pzf_pkg::ZONE_MASK_RESET;  // [R8]
            zone_status_r <= {pzf_pkg::ZONE_FIELD_RESET, pzf_pkg::ZONE_FIELD_RESET};  // [R12]
            zone_cfg_r <= {pzf_pkg::ZONE_FIELD_RESET, pzf_pkg::ZONE_FIELD_RESET};  // [R12]
            sel_freq_r <= 1'b0;
            sel_zone_r <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            pu_cnt_r <= pu_cnt_nxt;
            pu_done_r <= pu_done_nxt;
            en_prev_r <= en_prev_nxt;
            freq_status_r <= freq_status_nxt;
            freq_cfg_r <= freq_cfg_nxt;
            downstep_r <= downstep_nxt;
            zone_mask_r <= zone_mask_nxt;
            zone_status_r <= zone_status_nxt;
            zone_cfg_r <= zone_cfg_nxt;
            sel_freq_r <= sel_freq_nxt;
            sel_zone_r <= sel_zone_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // =====================================================================
    // effective settings
    // =====================================================================
    logic [5:0] zone_word;
    logic [2:0] zone_first_code;
    logic [2:0] zone_second_code;
    logic [2:0] zone_first_lvl;
    logic [2:0] zone_second_lvl;

    assign zone_word = sel_zone_r ? zone_cfg_r : zone_status_r;  // [R11]
    assign zone_first_code = zone_word[pzf_pkg::ZONE_FIRST_LSB +: pzf_pkg::ZONE_FIELD_W];
    assign zone_second_code = zone_word[pzf_pkg::ZONE_SECOND_LSB +: pzf_pkg::ZONE_FIELD_W];

    // reserved codes fall back to level 0
    always_comb
    begin
        if (zone_first_code <= pzf_pkg::ZONE_CODE_MAX_FIRST)
            zone_first_lvl = zone_first_code;  // [R12]
        else
            zone_first_lvl = 3'h0;  // [R12]
        if (zone_second_code == pzf_pkg::ZONE_CODE_ALIAS)
            zone_second_lvl = pzf_pkg::ZONE_LEVEL_TOP_SECOND;  // [R13]
        else if (zone_second_code < pzf_pkg::ZONE_CODE_ALIAS)
            zone_second_lvl = zone_second_code;  // [R13]
        else
            zone_second_lvl = 3'h0;  // [R13]
    end

    logic [4:0] freq_code_r;
    logic [2:0] zone_first_lvl_r;
    logic [2:0] zone_second_lvl_r;
    logic zone_mode_r;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            freq_code_r <= pzf_pkg::FREQ_RESET;
            zone_first_lvl_r <= pzf_pkg::ZONE_FIELD_RESET;
            zone_second_lvl_r <= pzf_pkg::ZONE_FIELD_RESET;
            zone_mode_r <= 1'b0;
        end
        else
        begin
            freq_code_r <= sel_freq_r ? freq_cfg_r : freq_status_r;  // [R14]
            zone_first_lvl_r <= zone_first_lvl;
            zone_second_lvl_r <= zone_second_lvl;
            zone_mode_r <= save_low_s && !save_high_s;  // [R7]
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign REG_RDATA = rdata_r;
    assign FREQ_CODE = freq_code_r;
    assign VOLTAGE_CODE_DOWNSTEP_EN = downstep_r;  // [R2]
    assign ZONE_ENABLE_MASK = zone_mask_r;  // [R7]
    assign ZONE_MODE_ACTIVE = zone_mode_r;
    assign ZONE_FIRST_LEVEL = zone_first_lvl_r;
    assign ZONE_SECOND_LEVEL = zone_second_lvl_r;

endmodule : pzf_regs

/* verification/pzf_regs_assertions.sv */
/* pzf_regs_assertions: port checks of pzf_regs, bound after the module.
   assumes one clock domain and an async active-low reset. */
`timescale 1ns/1ns
module pzf_regs_assertions (
    input wire logic CLK_SYS, // clock
    input wire logic RSTN, // reset
    input wire logic [7:0] REG_ADDR, // offset
    input wire logic REG_WR, // write
    input wire logic [7:0] REG_WDATA, // wdata
    input wire logic REG_RD, // read
    input wire logic [7:0] REG_RDATA, // rdata
    input wire logic [7:0] SECFN_LATCH_A, // latch a
    input wire logic [7:0] SECFN_LATCH_B, // latch b
    input wire logic POWER_SAVING_INPUT_LOW, // pin low
    input wire logic POWER_SAVING_INPUT_HIGH, // pin high
    input wire logic [3:0] PHASE_ACTIVE, // phases
    input wire logic [4:0] FREQ_CODE, // freq
    input wire logic VOLTAGE_CODE_DOWNSTEP_EN, // downstep
    input wire logic [4:0] ZONE_ENABLE_MASK, // mask
    input wire logic ZONE_MODE_ACTIVE, // zone mode
    input wire logic [2:0] ZONE_FIRST_LEVEL, // level 1
    input wire logic [2:0] ZONE_SECOND_LEVEL // level 2
);
    // ==========
    // properties
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    sequence rd_at(logic [7:0] a);
        REG_RD && REG_ADDR == a;
    endsequence
    sequence freq_by_strap;
        SECFN_LATCH_A == SECFN_LATCH_B && !SECFN_LATCH_A[5];
    endsequence
    sequence pin_low_only;
        POWER_SAVING_INPUT_LOW && !POWER_SAVING_INPUT_HIGH;
    endsequence
    a_downstep_write: assert property (
        REG_WR && REG_ADDR == 8'h31 |=>
            {7'h0, VOLTAGE_CODE_DOWNSTEP_EN} == ($past(REG_WDATA) & 8'h01))
        else $error("downstep bit not taken from write");
    a_mask_write: assert property (
        REG_WR && REG_ADDR == 8'h34 |=> {3'h0, ZONE_ENABLE_MASK} == ($past(REG_WDATA) & 8'h1f))
        else $error("zone mask not taken from write");
    a_downstep_read: assert property (
        rd_at(8'h31) |=> REG_RDATA == {7'h0, $past(VOLTAGE_CODE_DOWNSTEP_EN)})
        else $error("downstep read wrong");
    a_level_code: assert property (
        rd_at(8'h32) |=> REG_RDATA[7:2] == 6'h00 && REG_RDATA[1:0] != 2'h3)
        else $error("saving level read wrong");
    a_phase_live: assert property (
        rd_at(8'h33) |=> REG_RDATA == {4'h0, $past(PHASE_ACTIVE)})
        else $error("phase status read wrong");
    a_freq_even: assert property (
        rd_at(8'h2f) |=> REG_RDATA[0] == 1'b0 && REG_RDATA[7:5] == 3'h0)
        else $error("freq status not even");
    a_zone_rsv: assert property (
        REG_RD && REG_ADDR inside {8'h35, 8'h36} |=> REG_RDATA[7:6] == 2'h0)
        else $error("zone reserved bits set");
    a_level_range: assert property (
        ZONE_FIRST_LEVEL <= 3'h4 && ZONE_SECOND_LEVEL <= 3'h3)
        else $error("zone level out of range");
    a_freq_strap: assert property (
        freq_by_strap [*3] |-> !FREQ_CODE[0])
        else $error("odd freq code without select");
    a_mode_sync: assert property (
        pin_low_only [*4] |-> ZONE_MODE_ACTIVE)
        else $error("zone mode not active");
endmodule : pzf_regs_assertions

bind pzf_regs pzf_regs_assertions i_chk (.*);

/* verification/pzf_host.sv */
/* pzf_host: register host standing in for the serial engine.
   assumes clk is the design clock; all changes made on falling edges. */
`timescale 1ns/1ns
module pzf_host (
    input wire logic clk, // clock
    output logic [7:0] addr, // offset
    output logic wr, // write strobe
    output logic [7:0] wdata, // write data
    output logic rd, // read strobe
    input wire logic [7:0] rdata, // read data
    output logic [7:0] lat_a, // latch a
    output logic [7:0] lat_b // latch b
);
    // ==========
    // bus tasks
    initial
    begin
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
        rd = 1'b0;
        lat_a = 8'h00;
        lat_b = 8'h00;
    end
    // released lines show the inverse of the last value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask : read_reg
    // same byte to both latches, either order; both=0 leaves them apart
    task automatic set_latch(input logic [7:0] v, input bit b_first, input bit both);
        @(negedge clk);
        if (b_first)
            lat_b = v;
        else
            lat_a = v;
        if (both)
        begin
            @(negedge clk);
            if (b_first)
                lat_a = v;
            else
                lat_b = v;
        end
    endtask : set_latch
endmodule : pzf_host

/* verification/pzf_regs_test.sv */
/* pzf_regs_test: self-checking bench of pzf_regs against a register model.
   assumes pzf_host and the bound checker are compiled before it. */
`timescale 1ns/1ns
module pzf_regs_test;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ps_low = 1'b0;
    logic ps_high = 1'b0;
    logic en_pin = 1'b0;
    logic [4:0] fstrap = 5'h0b;
    logic [2:0] zs1 = 3'h3;
    logic [2:0] zs2 = 3'h4;
    logic [3:0] phase = 4'h0;
    logic [7:0] addr, wdata, rdata, lat_a, lat_b;
    logic wr, rd, dn_en, zmode;
    logic [4:0] fcode, zmask;
    logic [2:0] lv1, lv2;
    logic [15:0] lf = 16'h1aa0; // seed 6816
    int mdl [int];
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] offs [$] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h50};

    pzf_host i_host (.clk(clk_sys), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
        .rdata(rdata), .lat_a(lat_a), .lat_b(lat_b));
    pzf_regs i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .SECFN_LATCH_A(lat_a),
        .SECFN_LATCH_B(lat_b), .POWER_SAVING_INPUT_LOW(ps_low),
        .POWER_SAVING_INPUT_HIGH(ps_high), .ENABLE_PIN(en_pin), .FREQ_STRAP_SELECT(fstrap),
        .ZONE_STRAP_FIRST(zs1), .ZONE_STRAP_SECOND(zs2), .PHASE_ACTIVE(phase),
        .FREQ_CODE(fcode), .VOLTAGE_CODE_DOWNSTEP_EN(dn_en), .ZONE_ENABLE_MASK(zmask),
        .ZONE_MODE_ACTIVE(zmode), .ZONE_FIRST_LEVEL(lv1), .ZONE_SECOND_LEVEL(lv2));

    // ==========
    // clock, timeout, helpers
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            summarize();
        end
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic int lvl1(input int c);
        return (c <= 4) ? c : 0;
    endfunction : lvl1
    function automatic int lvl2(input int c);
        return (c < 4) ? c : ((c == 4) ? 3 : 0);
    endfunction : lvl2
    function automatic int exp_rd(input int a);
        if (a == 8'h32)
            return ps_high ? 2 : (ps_low ? 1 : 0);
        if (a == 8'h33)
            return phase;
        return mdl.exists(a) ? mdl[a] : 0;
    endfunction : exp_rd
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h30, 8'h34: mdl[a] = d & 8'h1f;
            8'h31: mdl[a] = d & 8'h01;
            8'h36: mdl[a] = d & 8'h3f;
            default: ;
        endcase
        i_host.write_reg(a, d);
    endtask : mwr
    task automatic chk_rd(input logic [7:0] a);
        logic [7:0] v;
        i_host.read_reg(a, v);
        check(v, 8'(exp_rd(a)));
    endtask : chk_rd
    task automatic chk_zone(input int f, input int s);
        check({5'h0, lv1}, 8'(lvl1(f)));
        check({5'h0, lv2}, 8'(lvl2(s)));
    endtask : chk_zone
    task automatic done(input int n);
        $display("test %0d done", n);
    endtask : done
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // ==========
    // main sequence
    initial
    begin
        idle(10);
        rstn = 1'b1;
        idle(4);
        mdl[8'h2f] = 8'h0a;
        mdl[8'h30] = 8'h00;
        mdl[8'h31] = 8'h01;
        mdl[8'h34] = 8'h1f;
        mdl[8'h35] = 8'h1c;
        mdl[8'h36] = 8'h1c;
        foreach (offs[i])
            chk_rd(offs[i]);
        check({3'h0, fcode}, 8'h0a);
        chk_zone(3, 4);
        done(1);
        mwr(8'h31, 8'hfe);
        check({7'h0, dn_en}, 8'h00);
        foreach (offs[i])
        begin
            lf = lfsr_next(lf);
            mwr(offs[i], lf[7:0]);
        end
        foreach (offs[i])
            chk_rd(offs[i]);
        check({7'h0, dn_en}, 8'(mdl[8'h31]));
        check({3'h0, zmask}, 8'(mdl[8'h34]));
        done(2);
        for (int k = 0; k < 4; k++)
        begin
            {ps_high, ps_low} = 2'(k);
            lf = lfsr_next(lf);
            phase = lf[3:0];
            idle(4);
            chk_rd(8'h32);
            chk_rd(8'h33);
            check({7'h0, zmode}, {7'h0, k == 1});
        end
        done(3);
        for (int c = 0; c < 8; c++)
        begin
            en_pin = 1'b0;
            zs1 = 3'(c);
            zs2 = 3'(7 - c);
            idle(3);
            en_pin = 1'b1;
            idle(6);
            mdl[8'h35] = c * 8 + 7 - c;
            chk_rd(8'h35);
            chk_rd(8'h36);
            chk_zone(c, 7 - c);
        end
        done(4);
        mwr(8'h36, 8'h14);
        mwr(8'h30, 8'h13);
        i_host.set_latch(8'h22, 1'b0, 1'b0);
        idle(4);
        chk_zone(7, 0);
        check({3'h0, fcode}, 8'h0a);
        i_host.set_latch(8'h22, 1'b1, 1'b1);
        idle(3);
        chk_zone(2, 4);
        check({3'h0, fcode}, 8'h13);
        i_host.set_latch(8'h00, 1'b1, 1'b1);
        idle(3);
        chk_zone(7, 0);
        check({3'h0, fcode}, 8'h0a);
        done(5);
        summarize();
    end
endmodule : pzf_regs_test
